// ---- alarm_relay_controller.sv ----
// Two-relay alarm controller: condition decode, action, polarity, power-up mute.
// Assumes all inputs synchronous to clk and held stable between ticks.
//
// What this block does
// - Accel mode exists only for relay one
// - Timer mode exists only for relay two
// - Absolute alarm: below low or reaching high, strictly above high outside mashing
// - Offset alarm around set point, mashing only
// - Accel: active below threshold or set point
// - Timer: active below start or done
// - Timer mode with countdown disabled: active unless power-up muted
// - Close-on-alarm: contacts close when active, default
// - Open-on-alarm: contacts open when active
// - Latch holds until reset or key
// - Single pulse of 1 to 100 seconds
// - Follow action tracks condition directly
// - Power-up mute blocks until release condition
// - Mute release: set point or boil start
// - Boil accel mute needs mashing set point reached
// - No mute release for timer or boil offset
// - Enabled keys cancel latch or follow only
// - Hysteresis band delays alarm release
// - Either limit may be switched off
`timescale 1ns/1ps

module alarm_relay_controller
  import alarm_relay_pkg::*;
#(
  parameter int unsigned SECOND_COUNT = SECOND_CYCLES  // Cycles per one-second tick
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // System tick, one-cycle pulse at evaluation rate
  input  wire logic        tick,
  // Process inputs
  input  wire process_in_s proc_in,
  // Relay configuration
  input  wire relay_cfg_s  relay_one_cfg,
  input  wire relay_cfg_s  relay_two_cfg,
  // Operator keys
  input  wire logic        key_enable,
  input  wire logic        relay_one_key,
  input  wire logic        relay_two_key,
  // Relay outputs
  output logic             relay_one_contact,
  output logic             relay_two_contact,
  output logic [1:0]       relay_active
);

  // Second strobe divider width
  localparam int unsigned SEC_W = $clog2(SECOND_COUNT + 1);

  // Per-relay state
  logic [1:0]               high_alarm_reg;    // Upper alarm held
  logic [1:0]               low_alarm_reg;     // Lower alarm held
  logic [1:0]               cond_prev_reg;     // Condition at previous tick
  logic [1:0]               latched_reg;       // Latch hold
  logic [1:0]               cancel_reg;        // Key cancel until condition clears
  logic [1:0]               mute_met_reg;      // Mute release seen
  logic [1:0]               active_reg;        // Final active state
  logic [PULSE_W-1:0]       pulse_cnt_reg [2]; // Seconds left in pulse
  logic [SEC_W-1:0]         sec_cnt_reg;       // One-second divider
  logic                     sec_pulse;         // One-cycle second strobe

  // Clamp pulse length to its legal span
  function automatic logic [PULSE_W-1:0] clamp_pulse(input logic [PULSE_W-1:0] s);
    if (s < PULSE_MIN_S) begin
      return PULSE_MIN_S;
    end else if (s > PULSE_MAX_S) begin
      return PULSE_MAX_S;
    end else begin
      return s;
    end
  endfunction

  // Second strobe so pulse lengths are in seconds regardless of tick rate
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_cnt_reg <= '0;
    end else if (sec_cnt_reg == SEC_W'(SECOND_COUNT - 1)) begin
      sec_cnt_reg <= '0;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 1'b1;
    end
  end
  assign sec_pulse = (sec_cnt_reg == SEC_W'(SECOND_COUNT - 1));

  // Shared views of the process inputs
  logic signed [TEMP_W:0] pv;
  logic signed [TEMP_W:0] sv;
  logic                   mashing;
  assign pv      = {proc_in.measured_temp[TEMP_W-1], proc_in.measured_temp};
  assign sv      = {proc_in.target_temp[TEMP_W-1], proc_in.target_temp};
  assign mashing = (proc_in.process == mash_process);

  genvar r;
  generate
    for (r = 0; r < 2; r++) begin : g_relay
      relay_cfg_s             cfg;
      logic                   key;
      logic signed [TEMP_W:0] hi_thr;       // High trip point
      logic signed [TEMP_W:0] lo_thr;       // Low trip point
      logic signed [TEMP_W:0] band;         // Release band widened
      logic                   hi_trip;
      logic                   hi_clear;
      logic                   lo_trip;
      logic                   lo_clear;
      logic                   hi_next;
      logic                   lo_next;
      logic                   cond;         // Raw relay condition
      logic                   mute_release; // Mute end condition now
      logic                   muted;
      logic                   gated;        // Condition after mute
      logic                   rise;
      logic                   key_ok;
      logic                   act_next;

      assign cfg  = (r == 0) ? relay_one_cfg : relay_two_cfg;
      assign key  = (r == 0) ? relay_one_key : relay_two_key;
      assign band = {1'b0, cfg.release_band};

      // Trip points: absolute limits or offsets from set point
      always_comb begin
        if (cfg.mode == offset_alarm_mode) begin
          hi_thr = sv + {cfg.upper_limit[TEMP_W-1], cfg.upper_limit};
          lo_thr = sv - {cfg.lower_limit[TEMP_W-1], cfg.lower_limit};
        end else begin
          hi_thr = {cfg.upper_limit[TEMP_W-1], cfg.upper_limit};
          lo_thr = {cfg.lower_limit[TEMP_W-1], cfg.lower_limit};
        end
      end

      // Mashing and offset trip at or above high; absolute outside mashing strictly above
      assign hi_trip  = cfg.upper_on &&
                        ((mashing || cfg.mode == offset_alarm_mode) ? (pv >= hi_thr)
                                                                    : (pv > hi_thr));
      assign lo_trip  = cfg.lower_on && (pv < lo_thr);
      // Release only past the band
      assign hi_clear = pv < (hi_thr - band);
      assign lo_clear = pv >= (lo_thr + band);
      assign hi_next  = cfg.upper_on && (hi_trip || (high_alarm_reg[r] && !hi_clear));
      assign lo_next  = cfg.lower_on && (lo_trip || (low_alarm_reg[r] && !lo_clear));

      // Condition per mode
      always_comb begin
        case (cfg.mode)
          absolute_alarm_mode: begin
            cond = hi_next || lo_next;
          end
          offset_alarm_mode: begin
            cond = mashing && (hi_next || lo_next);
          end
          accel_follow_mode: begin
            if (r != 0) begin
              cond = 1'b0;
            end else if (mashing) begin
              cond = pv < sv;
            end else begin
              cond = pv < {proc_in.boil_heatup_threshold[TEMP_W-1],
                           proc_in.boil_heatup_threshold};
            end
          end
          countdown_follow_mode: begin
            if (r != 1) begin
              cond = 1'b0;
            end else if (!proc_in.countdown_enable) begin
              cond = 1'b1;
            end else if (mashing) begin
              cond = (pv < {proc_in.mash_countdown_start_temp[TEMP_W-1],
                            proc_in.mash_countdown_start_temp})
                     || proc_in.countdown_done;
            end else begin
              cond = (pv < {proc_in.boil_countdown_start_temp[TEMP_W-1],
                            proc_in.boil_countdown_start_temp})
                     || proc_in.countdown_done;
            end
          end
          default: begin
            cond = 1'b0;
          end
        endcase
      end

      // Mute release condition per mode
      always_comb begin
        case (cfg.mode)
          absolute_alarm_mode: begin
            mute_release = mashing ? (pv >= sv)
                         : (pv >= {proc_in.boil_countdown_start_temp[TEMP_W-1],
                                   proc_in.boil_countdown_start_temp});
          end
          offset_alarm_mode: begin
            mute_release = mashing && (pv >= sv);
          end
          accel_follow_mode: begin
            mute_release = pv >= sv;
          end
          default: begin
            mute_release = 1'b0;
          end
        endcase
      end

      assign muted  = cfg.powerup_mute && !mute_met_reg[r];
      assign gated  = cond && !muted;
      assign rise   = gated && !cond_prev_reg[r];
      assign key_ok = key_enable && key && (cfg.action != single_shot_action);

      // Hysteresis alarm state, updated on tick
      always_ff @(posedge clk) begin
        if (rst) begin
          high_alarm_reg[r] <= 1'b0;
          low_alarm_reg[r]  <= 1'b0;
        end else if (tick) begin
          high_alarm_reg[r] <= hi_next;
          low_alarm_reg[r]  <= lo_next;
        end
      end

      // Mute release is sticky once seen
      always_ff @(posedge clk) begin
        if (rst) begin
          mute_met_reg[r] <= 1'b0;
        end else if (tick && mute_release) begin
          mute_met_reg[r] <= 1'b1;
        end
      end

      // Edge memory for pulse start
      always_ff @(posedge clk) begin
        if (rst) begin
          cond_prev_reg[r] <= 1'b0;
        end else if (tick) begin
          cond_prev_reg[r] <= gated;
        end
      end

      // Latch: sets on condition, released only by reset or key
      always_ff @(posedge clk) begin
        if (rst) begin
          latched_reg[r] <= 1'b0;
        end else if (key_ok) begin
          latched_reg[r] <= 1'b0;
        end else if (tick && gated && cfg.action == latch_action) begin
          latched_reg[r] <= 1'b1;
        end
      end

      // Key cancel in follow action lasts until the condition drops
      always_ff @(posedge clk) begin
        if (rst) begin
          cancel_reg[r] <= 1'b0;
        end else if (key_ok && cfg.action == follow_action) begin
          cancel_reg[r] <= 1'b1;
        end else if (tick && !gated) begin
          cancel_reg[r] <= 1'b0;
        end
      end

      // Pulse counter in seconds; a key press does not cut it short
      always_ff @(posedge clk) begin
        if (rst) begin
          pulse_cnt_reg[r] <= '0;
        end else if (tick && rise && cfg.action == single_shot_action) begin
          pulse_cnt_reg[r] <= clamp_pulse(cfg.pulse_seconds);
        end else if (sec_pulse && pulse_cnt_reg[r] != '0) begin
          pulse_cnt_reg[r] <= pulse_cnt_reg[r] - 1'b1;
        end
      end

      // Action select
      always_comb begin
        case (cfg.action)
          latch_action: begin
            act_next = latched_reg[r] || (gated && !key_ok);
          end
          single_shot_action: begin
            act_next = pulse_cnt_reg[r] != '0;
          end
          default: begin
            act_next = gated && !cancel_reg[r] && !key_ok;
          end
        endcase
      end

      // Registered active state
      always_ff @(posedge clk) begin
        if (rst) begin
          active_reg[r] <= 1'b0;
        end else begin
          active_reg[r] <= act_next;
        end
      end
    end
  endgenerate

  // Contact drive from polarity; reset shows inactive contacts per default
  always_ff @(posedge clk) begin
    if (rst) begin
      relay_one_contact <= 1'b0;
      relay_two_contact <= 1'b0;
    end else begin
      relay_one_contact <= act_next_pol(active_reg[0], relay_one_cfg.polarity);
      relay_two_contact <= act_next_pol(active_reg[1], relay_two_cfg.polarity);
    end
  end

  // Contact closed when active for close-on-alarm, open when active otherwise
  function automatic logic act_next_pol(input logic act, input polarity_e pol);
    return (pol == open_on_alarm) ? !act : act;
  endfunction

  assign relay_active = active_reg;

endmodule

// ---- alarm_relay_pkg.sv ----
// Package for the two-relay alarm controller.
// Assumes one 100 MHz clock and signed integer temperatures in display units.
package alarm_relay_pkg;

  // Clock rate and tick divider
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SECOND_S        = 1;
  localparam int unsigned SECOND_CYCLES   = CLK_HZ * SECOND_S;
  // Temperature word width
  localparam int unsigned TEMP_W          = 16;
  // Pulse length field width and limits, in seconds
  localparam int unsigned PULSE_W         = 7;
  localparam logic [6:0]  PULSE_MIN_S     = 7'h01;
  localparam logic [6:0]  PULSE_MAX_S     = 7'h64;
  localparam logic [6:0]  PULSE_RESET_S   = 7'h05;

  // Relay mode selector; accel valid only on relay one, timer only on relay two
  typedef enum logic [2:0] {
    relay_off,
    absolute_alarm_mode,
    offset_alarm_mode,
    accel_follow_mode,
    countdown_follow_mode
  } relay_mode_e;

  // Contact polarity
  typedef enum logic {
    close_on_alarm,
    open_on_alarm
  } polarity_e;

  // Relay action
  typedef enum logic [1:0] {
    follow_action,
    latch_action,
    single_shot_action
  } action_e;

  // Process control mode
  typedef enum logic [1:0] {
    mash_process,
    boil_process,
    distill_process
  } process_e;

  // Per-relay configuration
  typedef struct packed {
    relay_mode_e              mode;
    polarity_e                polarity;
    action_e                  action;
    logic                     powerup_mute;
    logic                     upper_on;
    logic signed [TEMP_W-1:0] upper_limit;
    logic                     lower_on;
    logic signed [TEMP_W-1:0] lower_limit;
    logic [TEMP_W-1:0]        release_band;
    logic [PULSE_W-1:0]       pulse_seconds;
  } relay_cfg_s;

  // Shared process inputs
  typedef struct packed {
    process_e                 process;
    logic signed [TEMP_W-1:0] measured_temp;
    logic signed [TEMP_W-1:0] target_temp;
    logic signed [TEMP_W-1:0] boil_heatup_threshold;
    logic signed [TEMP_W-1:0] boil_countdown_start_temp;
    logic signed [TEMP_W-1:0] mash_countdown_start_temp;
    logic                     countdown_enable;
    logic                     countdown_done;
  } process_in_s;

endpackage

// ---- alarm_relay_controller_props.sv ----
// Assertion checker for the two-relay alarm controller.
// Assumes settings change only under reset; attached by the bind at the foot.
`timescale 1ns/1ps

module alarm_relay_props
  import alarm_relay_pkg::*;
#(
  parameter int unsigned SECOND_COUNT = 10  // Cycles per second tick
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Stimulus side
  input wire logic        tick,
  input wire process_in_s proc_in,
  input wire relay_cfg_s  relay_one_cfg,
  input wire relay_cfg_s  relay_two_cfg,
  input wire logic        key_enable,
  input wire logic        relay_one_key,
  input wire logic        relay_two_key,
  // Relay outputs
  input wire logic        relay_one_contact,
  input wire logic        relay_two_contact,
  input wire logic [1:0]  relay_active
);
  logic        key_seen_reg;  // Enabled key pressed since reset
  logic        key_hit;       // Key press now or earlier
  logic        f1, f2;        // Plain follow, no mute, no key history
  logic        mash;          // Mashing process selected
  logic        pol1, pol2;    // Open-on-alarm selected
  logic [31:0] run_cnt_reg;   // Cycles relay one has been active

  assign key_hit = key_seen_reg | (key_enable & (relay_one_key | relay_two_key));
  assign f1      = relay_one_cfg.action == follow_action && !relay_one_cfg.powerup_mute
                   && !key_hit;
  assign f2      = relay_two_cfg.action == follow_action && !relay_two_cfg.powerup_mute
                   && !key_hit;
  assign mash    = proc_in.process == mash_process;
  assign pol1    = relay_one_cfg.polarity == open_on_alarm;
  assign pol2    = relay_two_cfg.polarity == open_on_alarm;

  // Sticky, since a cancel in follow action outlives the press
  always_ff @(posedge clk) begin
    if (rst) key_seen_reg <= 1'b0;
    else if (key_hit) key_seen_reg <= 1'b1;
  end

  // Activation length; too long for a repetition operator
  always_ff @(posedge clk) begin
    if (rst || !relay_active[0]) run_cnt_reg <= 32'h0;
    else run_cnt_reg <= run_cnt_reg + 32'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_reset;
    disable iff (1'b0)
    rst |=> relay_active == 2'b00 && !relay_one_contact && !relay_two_contact;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
  property p_pol_one;
    !$past(rst) |-> relay_one_contact == ($past(relay_active[0]) ^ $past(pol1));
  endproperty
  a_pol_one: assert property (p_pol_one)
    else $error("relay one contact polarity wrong");
  property p_pol_two;
    !$past(rst) |-> relay_two_contact == ($past(relay_active[1]) ^ $past(pol2));
  endproperty
  a_pol_two: assert property (p_pol_two)
    else $error("relay two contact polarity wrong");
  property p_abs_high;
    tick && f1 && mash && relay_one_cfg.mode == absolute_alarm_mode && relay_one_cfg.upper_on
    && proc_in.measured_temp >= relay_one_cfg.upper_limit |=> relay_active[0];
  endproperty
  a_abs_high: assert property (p_abs_high)
    else $error("high alarm missed in mashing");
  property p_boil_strict;
    tick && f1 && !mash && relay_one_cfg.mode == absolute_alarm_mode && !relay_active[0]
    && proc_in.measured_temp == relay_one_cfg.upper_limit
    && proc_in.measured_temp >= relay_one_cfg.lower_limit |=> !relay_active[0];
  endproperty
  a_boil_strict: assert property (p_boil_strict)
    else $error("boiling high alarm at limit");
  property p_offset_boil;
    tick && f2 && !mash && relay_two_cfg.mode == offset_alarm_mode |=> !relay_active[1];
  endproperty
  a_offset_boil: assert property (p_offset_boil)
    else $error("offset alarm outside mashing");
  property p_timer_off;
    tick && f2 && relay_two_cfg.mode == countdown_follow_mode
    && !proc_in.countdown_enable |=> relay_active[1];
  endproperty
  a_timer_off: assert property (p_timer_off)
    else $error("timer mode idle with timer off");
  property p_refused;
    tick && f1 && f2 && relay_one_cfg.mode == countdown_follow_mode
    && relay_two_cfg.mode == accel_follow_mode |=> relay_active == 2'b00;
  endproperty
  a_refused: assert property (p_refused)
    else $error("unsupported mode activated relay");
  property p_latch;
    relay_active[0] && relay_one_cfg.action == latch_action && !key_hit |=> relay_active[0];
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched relay released");
  property p_mute_timer;
    relay_two_cfg.mode == countdown_follow_mode && relay_two_cfg.powerup_mute
    |-> !relay_active[1];
  endproperty
  a_mute_timer: assert property (p_mute_timer)
    else $error("muted timer relay activated");
  property p_pulse;
    $fell(relay_active[0]) && relay_one_cfg.action == single_shot_action
    |-> run_cnt_reg >= (32'(relay_one_cfg.pulse_seconds) - 32'h1) * SECOND_COUNT;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse shorter than set length");
endmodule

bind alarm_relay_controller alarm_relay_props #(.SECOND_COUNT(SECOND_COUNT)) props (
  .clk(clk), .rst(rst), .tick(tick), .proc_in(proc_in), .relay_one_cfg(relay_one_cfg),
  .relay_two_cfg(relay_two_cfg), .key_enable(key_enable), .relay_one_key(relay_one_key),
  .relay_two_key(relay_two_key), .relay_one_contact(relay_one_contact),
  .relay_two_contact(relay_two_contact), .relay_active(relay_active));

// ---- relay_load_model.sv ----
// Behavioural relay load: counts closures and cycles held closed.
// Assumes a contact level, 1 = closed, sampled on the clock.
`timescale 1ns/1ps

module relay_load_model (
  // Clock and contact
  input  wire logic   clk,
  input  wire logic   contact,
  // Observations
  output logic [7:0]  closures,
  output logic [15:0] closed_cycles
);
  logic last_reg;  // Contact seen last cycle

  // A load has no reset; it starts counting at time zero
  initial begin
    closures = 8'h00;
    closed_cycles = 16'h0000;
    last_reg = 1'b0;
  end

  // Count pull-ins and closed time
  always @(posedge clk) begin
    closures <= closures + 8'(contact & !last_reg);
    closed_cycles <= closed_cycles + 16'(contact);
    last_reg <= contact;
  end
endmodule

// ---- test_alarm_relay_controller.sv ----
// Self-checking bench for the two-relay alarm controller.
// Assumes package, design, checker and load model are compiled before it.
`timescale 1ns/1ps

module test_alarm_relay_controller;
  import alarm_relay_pkg::*;
  localparam int unsigned SC = 10;  // Short second keeps pulses brief
  logic        clk, rst, tick, key_enable, relay_one_key, relay_two_key;
  process_in_s pi;                  // Shared process inputs
  relay_cfg_s  c1, c2;              // Relay settings
  logic        relay_one_contact, relay_two_contact;
  logic [1:0]  relay_active, st1, st2;
  logic [7:0]  clo1, base;
  logic [15:0] held1, hb;
  logic        dn;
  int          error_cnt, checked, seed, pv;
  int          ct[16] = '{199, 200, 198, 197, 196, 99, 100, 102, 103, 201, 170, 167, 130, 133,
                          150, 120};
  relay_mode_e m1_t[5] = '{absolute_alarm_mode, absolute_alarm_mode, accel_follow_mode,
                           accel_follow_mode, countdown_follow_mode};
  relay_mode_e m2_t[5] = '{offset_alarm_mode, offset_alarm_mode, countdown_follow_mode,
                           countdown_follow_mode, accel_follow_mode};
  process_e    pr_t[5] = '{mash_process, boil_process, mash_process, distill_process,
                           mash_process};

  `define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  alarm_relay_controller #(.SECOND_COUNT(SC)) DUT (
    .clk(clk), .rst(rst), .tick(tick), .proc_in(pi), .relay_one_cfg(c1), .relay_two_cfg(c2),
    .key_enable(key_enable), .relay_one_key(relay_one_key), .relay_two_key(relay_two_key),
    .relay_one_contact(relay_one_contact), .relay_two_contact(relay_two_contact),
    .relay_active(relay_active));
  relay_load_model load_one (.clk(clk), .contact(relay_one_contact), .closures(clo1),
    .closed_cycles(held1));
  relay_load_model load_two (.clk(clk), .contact(relay_two_contact), .closures(),
    .closed_cycles());

  // Settings with fixed limits; offset relay runs on its high side only
  function automatic relay_cfg_s mk(relay_mode_e m, polarity_e p, action_e a, logic mu);
    mk = '{m, p, a, mu, 1'b1, 16'sh00c8, 1'b1, 16'sh0064, 16'h0003, 7'h02};
    if (m == offset_alarm_mode) mk.upper_limit = 16'sh0014;
    if (m == offset_alarm_mode) mk.lower_on = 1'b0;
  endfunction

  // Next high/low alarm state, band of 3; strict high in boiling
  function automatic logic [1:0] alarm_nx(logic [1:0] st, int t, int up, int lo, logic s);
    alarm_nx[1] = st[1] ? t >= up - 3 : (s ? t > up : t >= up);
    alarm_nx[0] = st[0] ? t < lo + 3 : t < lo;
  endfunction

  // Expected activity of both relays in the random passes
  function automatic logic [1:0] expect_pair(int ps, int t, logic d);
    st1 = alarm_nx(st1, t, 200, 100, pr_t[ps] != mash_process);
    st2 = alarm_nx(st2, t, 170, -30000, 1'b0);
    case (ps)
      0: return {|st2, |st1};
      1: return {1'b0, |st1};
      2: return {t < 120 || d, t < 150};
      3: return {1'b1, t < 180};
      default: return 2'b00;
    endcase
  endfunction

  // New settings are applied under reset so no stale state carries over
  task automatic restart(relay_cfg_s a, relay_cfg_s b, process_e pr, logic ke, logic ce);
    @(posedge clk);
    rst <= 1'b1;
    c1 <= a;
    c2 <= b;
    pi.process <= pr;
    key_enable <= ke;
    pi.countdown_enable <= ce;
    st1 = 2'b00;
    st2 = 2'b00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  // One tick with a temperature and keys, then check state and contacts
  task automatic step(int t, logic d, logic [1:0] k, logic [1:0] e);
    @(posedge clk);
    pi.measured_temp <= 16'(t);
    pi.countdown_done <= d;
    relay_one_key <= k[0];
    relay_two_key <= k[1];
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    relay_one_key <= 1'b0;
    relay_two_key <= 1'b0;
    // A mute release or latch cancel settles an edge late; the contact trails by one more
    @(posedge clk);
    @(posedge clk);
    @(negedge clk);
    `CHK("relay_active", e, relay_active)
    `CHK("relay_one_contact", e[0] ^ c1.polarity, relay_one_contact)
    `CHK("relay_two_contact", e[1] ^ c2.polarity, relay_two_contact)
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence: random passes, then latch, key, mute and pulse cases
  initial begin
    seed = $urandom(32'he3b47227);
    rst = 1'b1;
    tick = 1'b0;
    key_enable = 1'b0;
    relay_one_key = 1'b0;
    relay_two_key = 1'b0;
    c1 = '0;
    c2 = '0;
    pi = '{mash_process, 16'sh0000, 16'sh0096, 16'sh00b4, 16'sh00c8, 16'sh0078, 1'b1, 1'b0};
    repeat (10) @(posedge clk);
    for (int ps = 0; ps < 5; ps++) begin
      restart(mk(m1_t[ps], polarity_e'(ps % 2), follow_action, 1'b0),
              mk(m2_t[ps], polarity_e'(ps % 2), follow_action, 1'b0), pr_t[ps], 1'b0, ps != 3);
      for (int i = 0; i < 46; i++) begin
        pv = (i < 16) ? ct[i] : 90 + int'($urandom_range(130));
        dn = 1'($urandom);
        step(pv, dn, '0, expect_pair(ps, pv, dn));
      end
    end
    restart(mk(absolute_alarm_mode, close_on_alarm, latch_action, 1'b0), '0, mash_process,
            1'b0, 1'b1);
    step(210, 1'b0, 2'b00, 2'b01);
    step(150, 1'b0, 2'b00, 2'b01);
    step(150, 1'b0, 2'b01, 2'b01);
    restart(mk(absolute_alarm_mode, close_on_alarm, latch_action, 1'b0), '0, mash_process,
            1'b1, 1'b1);
    step(210, 1'b0, 2'b00, 2'b01);
    step(150, 1'b0, 2'b01, 2'b00);
    // Key cancel in follow action holds until the condition drops once
    restart(mk(absolute_alarm_mode, close_on_alarm, follow_action, 1'b0), '0, mash_process,
            1'b1, 1'b1);
    step(210, 1'b0, 2'b00, 2'b01);
    step(210, 1'b0, 2'b01, 2'b00);
    step(150, 1'b0, 2'b00, 2'b00);
    step(210, 1'b0, 2'b00, 2'b01);
    restart(mk(absolute_alarm_mode, close_on_alarm, follow_action, 1'b1),
            mk(countdown_follow_mode, close_on_alarm, follow_action, 1'b1), mash_process, 1'b0,
            1'b0);
    step(90, 1'b0, 2'b00, 2'b00);
    step(160, 1'b0, 2'b00, 2'b00);
    step(90, 1'b0, 2'b00, 2'b01);
    restart(mk(accel_follow_mode, close_on_alarm, follow_action, 1'b1), '0, boil_process, 1'b0,
            1'b1);
    step(140, 1'b0, 2'b00, 2'b00);
    step(160, 1'b0, 2'b00, 2'b01);
    restart(mk(absolute_alarm_mode, close_on_alarm, single_shot_action, 1'b0), '0,
            mash_process, 1'b0, 1'b1);
    base = clo1;
    hb = held1;
    pi.measured_temp <= 16'sh00d2;
    tick <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK("pulse_length", 1'b1, (held1 - hb) inside {[16'h000a:16'h0015]})
    pi.measured_temp <= 16'sh0096;
    repeat (10) @(posedge clk);
    pi.measured_temp <= 16'sh00d2;
    repeat (60) @(posedge clk);
    tick <= 1'b0;
    `CHK("closures", 8'h02, 8'(clo1 - base))
    report_and_stop();
  end
endmodule
